//--- design/lcr_bank.sv
// laser control register bank: output values, sample rate and pin/address configuration
`timescale 1ns/1ps
module lcr_bank
	import lcr_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	// host byte port from the serial front end
	input  wire lcr_host_s   host_i,
	input  wire lcr_auth_s   auth_i,
	input  wire logic        stop_i,
	output logic      [7:0]  rdata_o,
	output logic             rd_valid_o,
	// lookup enables from the mode register
	input  wire logic        modulation_lut_enable_i,
	input  wire logic        aux1_lut_enable_i,
	input  wire logic        aux2_lut_enable_i,
	// end of temperature conversion with recalled table words
	input  wire logic        conv_done_i,
	input  wire logic [8:0]  mod_lut_data_i,
	input  wire logic [8:0]  aux1_lut_data_i,
	input  wire logic [8:0]  aux2_lut_data_i,
	// nonvolatile shadow recall after power up
	input  wire logic        nv_load_i,
	input  wire logic [7:0]  nv_rate_i,
	input  wire logic [7:0]  nv_pincfg_i,
	input  wire logic [7:0]  nv_outcfg_i,
	input  wire logic [7:0]  device_addr_i,
	// pins and loose status
	input  wire logic        signal_loss_input_i,
	input  wire logic        signal_loss_low_alarm_i,
	input  wire logic        rate_select_i,
	input  wire logic        gp_input1_i,
	// comparison results for the three flag groups
	input  wire logic        cmp_valid_i,
	input  wire logic [15:0] alarm_cmp_i,
	input  wire logic [15:0] qtrip_cmp_i,
	input  wire logic [15:0] warn_cmp_i,
	input  wire logic [2:0]  flag_clear_i,
	// results
	output logic      [8:0]  modulation_o,
	output logic      [8:0]  aux_output1_o,
	output logic      [8:0]  aux_output2_o,
	output logic      [2:0]  power_loop_rate_code_o,
	output logic      [7:0]  power_loop_period_cyc_o,
	output logic             signal_loss_output_o,
	output logic             rate_select_output_o,
	output logic             gp_output1_o,
	output logic      [7:0]  slave_addr_o,
	output logic      [7:0]  alarm_row_table_o,
	output logic      [15:0] alarm_flags_o,
	output logic      [15:0] qtrip_flags_o,
	output logic      [15:0] warn_flags_o,
	output logic             nv_write_o,
	output logic      [7:0]  nv_addr_o,
	output logic      [7:0]  nv_wdata_o
);
	// access rights
	// writes need the stronger grant; a read-only grant opens reads alone
	wire rd_ok = auth_i.top_password_level |
	             (auth_i.lower_password_level & (auth_i.table_rw_grant | auth_i.table_read_grant));
	wire wr_ok = auth_i.top_password_level |
	             (auth_i.lower_password_level & auth_i.table_rw_grant);

	// address decode
	// exact byte matches; the device-address byte is held outside this bank
	wire sel_mod_hi  = (host_i.addr == LCR_OFS_MOD_HI);
	wire sel_mod_lo  = (host_i.addr == LCR_OFS_MOD_LO);
	wire sel_aux1_hi = (host_i.addr == LCR_OFS_AUX1_HI);
	wire sel_aux1_lo = (host_i.addr == LCR_OFS_AUX1_LO);
	wire sel_aux2_hi = (host_i.addr == LCR_OFS_AUX2_HI);
	wire sel_aux2_lo = (host_i.addr == LCR_OFS_AUX2_LO);
	wire sel_rate    = (host_i.addr == LCR_OFS_RATE);
	wire sel_pincfg  = (host_i.addr == LCR_OFS_PINCFG);
	wire sel_outcfg  = (host_i.addr == LCR_OFS_OUTCFG);
	wire cfg_wr      = host_i.wr & wr_ok;

	logic [7:0]  rate_q;
	logic [7:0]  rate_d;
	logic [7:0]  pincfg_q;
	logic [7:0]  pincfg_d;
	logic [7:0]  outcfg_q;
	logic [7:0]  outcfg_d;
	logic [8:0]  mod_val;
	logic [8:0]  aux1_val;
	logic [8:0]  aux2_val;
	logic [8:0]  mod_app;
	logic [8:0]  aux1_app;
	logic [8:0]  aux2_app;
	logic [15:0] alarm_f;
	logic [15:0] qtrip_f;
	logic [15:0] warn_f;

	// three output value registers, all volatile
	// each keeps its own pending mark so a stop applies only what was written
	lcr_value_reg u_mod (
		.core_clk_i   (core_clk_i),
		.rst_i        (rst_i),
		.lut_enable_i (modulation_lut_enable_i),
		.wr_ok_i      (wr_ok),
		.wr_hi_i      (host_i.wr & sel_mod_hi),
		.wr_lo_i      (host_i.wr & sel_mod_lo),
		.wdata_i      (host_i.wdata),
		.conv_done_i  (conv_done_i),
		.lut_data_i   (mod_lut_data_i),
		.stop_i       (stop_i),
		.value_o      (mod_val),
		.applied_o    (mod_app)
	);
	lcr_value_reg u_aux1 (
		.core_clk_i   (core_clk_i),
		.rst_i        (rst_i),
		.lut_enable_i (aux1_lut_enable_i),
		.wr_ok_i      (wr_ok),
		.wr_hi_i      (host_i.wr & sel_aux1_hi),
		.wr_lo_i      (host_i.wr & sel_aux1_lo),
		.wdata_i      (host_i.wdata),
		.conv_done_i  (conv_done_i),
		.lut_data_i   (aux1_lut_data_i),
		.stop_i       (stop_i),
		.value_o      (aux1_val),
		.applied_o    (aux1_app)
	);
	lcr_value_reg u_aux2 (
		.core_clk_i   (core_clk_i),
		.rst_i        (rst_i),
		.lut_enable_i (aux2_lut_enable_i),
		.wr_ok_i      (wr_ok),
		.wr_hi_i      (host_i.wr & sel_aux2_hi),
		.wr_lo_i      (host_i.wr & sel_aux2_lo),
		.wdata_i      (host_i.wdata),
		.conv_done_i  (conv_done_i),
		.lut_data_i   (aux2_lut_data_i),
		.stop_i       (stop_i),
		.value_o      (aux2_val),
		.applied_o    (aux2_app)
	);

	// config writes keep only defined bits; shadow recall loads the stored copy
	// recall wins over a host write in the same cycle so power-up state is exact
	assign rate_d   = nv_load_i ? (nv_rate_i & LCR_MASK_RATE) :
	                  ((cfg_wr & sel_rate) ? (host_i.wdata & LCR_MASK_RATE) : rate_q);
	assign pincfg_d = nv_load_i ? (nv_pincfg_i & LCR_MASK_PINCFG) :
	                  ((cfg_wr & sel_pincfg) ? (host_i.wdata & LCR_MASK_PINCFG) : pincfg_q);
	assign outcfg_d = nv_load_i ? (nv_outcfg_i & LCR_MASK_OUTCFG) :
	                  ((cfg_wr & sel_outcfg) ? (host_i.wdata & LCR_MASK_OUTCFG) : outcfg_q);

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rate_q   <= LCR_RST_RATE;
			pincfg_q <= LCR_RST_PINCFG;
			outcfg_q <= LCR_RST_OUTCFG;
		end else begin
			rate_q   <= rate_d;
			pincfg_q <= pincfg_d;
			outcfg_q <= outcfg_d;
		end
	end

	// accepted config writes are forwarded to the nonvolatile store
	// raw byte goes out; reserved bits are masked again on recall
	logic       nv_write_q;
	logic [7:0] nv_addr_q;
	logic [7:0] nv_wdata_q;
	wire        nv_hit = cfg_wr & (sel_rate | sel_pincfg | sel_outcfg);

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			nv_write_q <= 1'b0;
			nv_addr_q  <= 8'h00;
			nv_wdata_q <= 8'h00;
		end else begin
			nv_write_q <= nv_hit;
			nv_addr_q  <= nv_hit ? host_i.addr : nv_addr_q;
			nv_wdata_q <= nv_hit ? host_i.wdata : nv_wdata_q;
		end
	end

	// read mux; refused or unmapped reads return zero
	// value high bytes carry bit 8 only, the upper seven read as zero
	wire [7:0] rd_mux =
		!rd_ok      ? 8'h00 :
		sel_mod_hi  ? {7'h00, mod_val[8]} :
		sel_mod_lo  ? mod_val[7:0] :
		sel_aux1_hi ? {7'h00, aux1_val[8]} :
		sel_aux1_lo ? aux1_val[7:0] :
		sel_aux2_hi ? {7'h00, aux2_val[8]} :
		sel_aux2_lo ? aux2_val[7:0] :
		sel_rate    ? rate_q :
		sel_pincfg  ? pincfg_q :
		sel_outcfg  ? outcfg_q : 8'h00;

	// read data holds until the next read so a slow host can fetch it
	logic [7:0] rdata_q;
	logic       rd_valid_q;

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_q    <= 8'h00;
			rd_valid_q <= 1'b0;
		end else begin
			rdata_q    <= host_i.rd ? rd_mux : rdata_q;
			rd_valid_q <= host_i.rd;
		end
	end

	// sample period lookup, counts at 100 ns per cycle
	// counts are tied to the 100 ns clock; another clock needs new counts
	logic [7:0] period_cyc;
	always_comb begin
		case (rate_q[2:0])
			3'h0:    period_cyc = LCR_SR_CYC0;
			3'h1:    period_cyc = LCR_SR_CYC1;
			3'h2:    period_cyc = LCR_SR_CYC2;
			3'h3:    period_cyc = LCR_SR_CYC3;
			3'h4:    period_cyc = LCR_SR_CYC4;
			3'h5:    period_cyc = LCR_SR_CYC5;
			3'h6:    period_cyc = LCR_SR_CYC6;
			default: period_cyc = LCR_SR_CYC7;
		endcase
	end

	// pin routing, registered so outputs stay glitch free
	// the force bit wins over the input pin; polarity applies after it
	wire los_pin   = signal_loss_input_i ^ pincfg_q[LCR_BIT_INVLOS];
	wire los_d     = pincfg_q[LCR_BIT_SIGNAL_LOSS_OUT_SOURCE] ? los_pin : signal_loss_low_alarm_i;
	wire rsel_d    = rate_select_i ^ pincfg_q[LCR_BIT_INVRS];
	wire gpo_act   = outcfg_q[LCR_BIT_FORCE] ? 1'b1 : gp_input1_i;
	wire gpo_d     = gpo_act ^ outcfg_q[LCR_BIT_INVO1];
	wire [7:0] sa_d  = pincfg_q[LCR_BIT_SLAVE_ADDR_SELECT] ? device_addr_i : LCR_DEF_SLAVE;
	wire [7:0] row_d = pincfg_q[LCR_BIT_ROW] ? LCR_ROW_TBL_HI : LCR_ROW_TBL_LO;

	logic        los_q;
	logic        rsel_q;
	logic        gpo_q;
	logic [7:0]  sa_q;
	logic [7:0]  row_q;
	logic [7:0]  per_q;
	logic [26:0] val_q;

	// pin outputs lag their inputs by one edge and idle low in reset
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			los_q  <= 1'b0;
			rsel_q <= 1'b0;
			gpo_q  <= 1'b0;
		end else begin
			los_q  <= los_d;
			rsel_q <= rsel_d;
			gpo_q  <= gpo_d;
		end
	end

	// address, row and period follow the config one edge late
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sa_q   <= LCR_DEF_SLAVE;
			row_q  <= LCR_ROW_TBL_LO;
			per_q  <= LCR_SR_CYC0;
		end else begin
			sa_q   <= sa_d;
			row_q  <= row_d;
			per_q  <= period_cyc;
		end
	end

	// applied values trail the value registers' own apply stage by one edge
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			val_q  <= 27'h0000000;
		end else begin
			val_q  <= {mod_app, aux1_app, aux2_app};
		end
	end

	// three flag groups, each with its own latch bit
	// clearing is a host pulse; a compare in the same cycle still sets
	lcr_sticky_flags u_alarm (
		.core_clk_i  (core_clk_i),
		.rst_i       (rst_i),
		.sticky_i    (outcfg_q[LCR_BIT_ALAT]),
		.cmp_valid_i (cmp_valid_i),
		.cmp_i       (alarm_cmp_i),
		.clear_i     (flag_clear_i[LCR_GRP_ALARM]),
		.flags_o     (alarm_f)
	);
	lcr_sticky_flags u_qtrip (
		.core_clk_i  (core_clk_i),
		.rst_i       (rst_i),
		.sticky_i    (outcfg_q[LCR_BIT_QLAT]),
		.cmp_valid_i (cmp_valid_i),
		.cmp_i       (qtrip_cmp_i),
		.clear_i     (flag_clear_i[LCR_GRP_QTRIP]),
		.flags_o     (qtrip_f)
	);
	lcr_sticky_flags u_warn (
		.core_clk_i  (core_clk_i),
		.rst_i       (rst_i),
		.sticky_i    (outcfg_q[LCR_BIT_WLAT]),
		.cmp_valid_i (cmp_valid_i),
		.cmp_i       (warn_cmp_i),
		.clear_i     (flag_clear_i[LCR_GRP_WARN]),
		.flags_o     (warn_f)
	);

	// outputs
	// every output is a plain copy of a flop, no logic after the registers
	assign rdata_o                = rdata_q;
	assign rd_valid_o             = rd_valid_q;
	assign modulation_o           = val_q[26:18];
	assign aux_output1_o          = val_q[17:9];
	assign aux_output2_o          = val_q[8:0];
	assign power_loop_rate_code_o = rate_q[2:0];
	assign power_loop_period_cyc_o = per_q;
	assign signal_loss_output_o   = los_q;
	assign rate_select_output_o   = rsel_q;
	assign gp_output1_o           = gpo_q;
	assign slave_addr_o           = sa_q;
	assign alarm_row_table_o      = row_q;
	assign alarm_flags_o          = alarm_f;
	assign qtrip_flags_o          = qtrip_f;
	assign warn_flags_o           = warn_f;
	assign nv_write_o             = nv_write_q;
	assign nv_addr_o              = nv_addr_q;
	assign nv_wdata_o             = nv_wdata_q;
endmodule // lcr_bank

//--- design/lcr_pkg.sv
// package with register map, field positions, reset values and timing for the laser control register bank
package lcr_pkg;
	// byte offsets within the control table
	localparam logic [7:0] LCR_OFS_MOD_HI   = 8'h82;
	localparam logic [7:0] LCR_OFS_MOD_LO   = 8'h83;
	localparam logic [7:0] LCR_OFS_AUX1_HI  = 8'h84;
	localparam logic [7:0] LCR_OFS_AUX1_LO  = 8'h85;
	localparam logic [7:0] LCR_OFS_AUX2_HI  = 8'h86;
	localparam logic [7:0] LCR_OFS_AUX2_LO  = 8'h87;
	localparam logic [7:0] LCR_OFS_RATE     = 8'h88;
	localparam logic [7:0] LCR_OFS_PINCFG   = 8'h89;
	localparam logic [7:0] LCR_OFS_OUTCFG   = 8'h8a;
	localparam logic [7:0] LCR_OFS_DEVADDR  = 8'h8c;
	// reset values
	localparam logic [8:0] LCR_RST_VALUE    = 9'h000;
	localparam logic [7:0] LCR_RST_RATE     = 8'h00;
	localparam logic [7:0] LCR_RST_PINCFG   = 8'h80;
	localparam logic [7:0] LCR_RST_OUTCFG   = 8'h00;
	// writable bit masks, reserved bits read zero
	localparam logic [7:0] LCR_MASK_RATE    = 8'h07;
	localparam logic [7:0] LCR_MASK_PINCFG  = 8'hbc;
	localparam logic [7:0] LCR_MASK_OUTCFG  = 8'hc7;
	// pin config field positions
	localparam int LCR_BIT_SIGNAL_LOSS_OUT_SOURCE   = 7;
	localparam int LCR_BIT_INVLOS = 5;
	localparam int LCR_BIT_SLAVE_ADDR_SELECT   = 4;
	localparam int LCR_BIT_ROW    = 3;
	localparam int LCR_BIT_INVRS  = 2;
	// output config field positions
	localparam int LCR_BIT_FORCE  = 7;
	localparam int LCR_BIT_INVO1  = 6;
	localparam int LCR_BIT_ALAT   = 2;
	localparam int LCR_BIT_QLAT   = 1;
	localparam int LCR_BIT_WLAT   = 0;
	// slave address and alarm row tables
	localparam logic [7:0] LCR_DEF_SLAVE    = 8'ha2;
	localparam logic [7:0] LCR_ROW_TBL_LO   = 8'h01;
	localparam logic [7:0] LCR_ROW_TBL_HI   = 8'h05;
	// output scale denominator
	localparam int LCR_AUX_SCALE = 512;
	// power loop sample periods in ns, and cycles at 100 ns clock
	localparam int LCR_CLK_NS = 100;
	localparam int LCR_SR_NS0 = 800;
	localparam int LCR_SR_NS1 = 1200;
	localparam int LCR_SR_NS2 = 1600;
	localparam int LCR_SR_NS3 = 2000;
	localparam int LCR_SR_NS4 = 2800;
	localparam int LCR_SR_NS5 = 3200;
	localparam int LCR_SR_NS6 = 4400;
	localparam int LCR_SR_NS7 = 6400;
	localparam logic [7:0] LCR_SR_CYC0 = 8'(LCR_SR_NS0 / LCR_CLK_NS);
	localparam logic [7:0] LCR_SR_CYC1 = 8'(LCR_SR_NS1 / LCR_CLK_NS);
	localparam logic [7:0] LCR_SR_CYC2 = 8'(LCR_SR_NS2 / LCR_CLK_NS);
	localparam logic [7:0] LCR_SR_CYC3 = 8'(LCR_SR_NS3 / LCR_CLK_NS);
	localparam logic [7:0] LCR_SR_CYC4 = 8'(LCR_SR_NS4 / LCR_CLK_NS);
	localparam logic [7:0] LCR_SR_CYC5 = 8'(LCR_SR_NS5 / LCR_CLK_NS);
	localparam logic [7:0] LCR_SR_CYC6 = 8'(LCR_SR_NS6 / LCR_CLK_NS);
	localparam logic [7:0] LCR_SR_CYC7 = 8'(LCR_SR_NS7 / LCR_CLK_NS);

	// host byte access as seen by the bank
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} lcr_host_s;

	// password state presented by the serial front end
	typedef struct packed {
		logic top_password_level;
		logic lower_password_level;
		logic table_rw_grant;
		logic table_read_grant;
	} lcr_auth_s;

	// flag comparison groups
	typedef enum logic [1:0] {
		LCR_GRP_ALARM,
		LCR_GRP_QTRIP,
		LCR_GRP_WARN
	} lcr_grp_e;
endpackage

//--- design/lcr_sticky_flags.sv
// one group of comparison flags, following or sticky
`timescale 1ns/1ps
module lcr_sticky_flags
	import lcr_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	input  wire logic        sticky_i,
	input  wire logic        cmp_valid_i,
	input  wire logic [15:0] cmp_i,
	input  wire logic        clear_i,
	output logic      [15:0] flags_o
);
	logic [15:0] flags_q;
	logic [15:0] flags_d;

	// new set wins over a clear in the same cycle
	always_comb begin
		flags_d = clear_i ? 16'h0000 : flags_q;
		if (cmp_valid_i)
			flags_d = sticky_i ? (flags_d | cmp_i) : cmp_i;
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i)
			flags_q <= 16'h0000;
		else
			flags_q <= flags_d;
	end

	assign flags_o = flags_q;
endmodule // lcr_sticky_flags

//--- design/lcr_value_reg.sv
// one 9-bit output value with lookup reload, gated host write and apply at stop
`timescale 1ns/1ps
module lcr_value_reg
	import lcr_pkg::*;
(
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	input  wire logic       lut_enable_i,
	input  wire logic       wr_ok_i,
	input  wire logic       wr_hi_i,
	input  wire logic       wr_lo_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       conv_done_i,
	input  wire logic [8:0] lut_data_i,
	input  wire logic       stop_i,
	output logic      [8:0] value_o,
	output logic      [8:0] applied_o
);
	logic [8:0] value_q;
	logic [8:0] value_d;
	logic [8:0] applied_q;
	logic [8:0] applied_d;
	logic       pend_q;
	logic       pend_d;
	wire        host_wr = wr_ok_i & ~lut_enable_i & (wr_hi_i | wr_lo_i);

	// lookup reload owns the value while enabled, host otherwise
	always_comb begin
		value_d = value_q;
		if (lut_enable_i) begin
			if (conv_done_i)
				value_d = lut_data_i;
		end else if (host_wr) begin
			if (wr_hi_i)
				value_d[8] = wdata_i[0];                 // upper seven bits dropped
			if (wr_lo_i)
				value_d[7:0] = wdata_i;
		end
	end

	// host values reach the output only at the stop; reloads apply at once
	assign pend_d    = stop_i ? 1'b0 : (pend_q | host_wr);
	assign applied_d = (lut_enable_i & conv_done_i) ? lut_data_i :
	                   ((stop_i & (pend_q | host_wr)) ? value_d : applied_q);

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			value_q   <= LCR_RST_VALUE;
			applied_q <= LCR_RST_VALUE;
			pend_q    <= 1'b0;
		end else begin
			value_q   <= value_d;
			applied_q <= applied_d;
			pend_q    <= pend_d;
		end
	end

	assign value_o   = value_q;
	assign applied_o = applied_q;
endmodule // lcr_value_reg

//--- verification/lcr_bank_monitor.sv
// concurrent checks on the laser control register bank ports
`timescale 1ns/1ps
module lcr_bank_monitor
	import lcr_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	input  wire lcr_host_s   host_i,
	input  wire lcr_auth_s   auth_i,
	input  wire logic        modulation_lut_enable_i,
	input  wire logic        conv_done_i,
	input  wire logic [8:0]  mod_lut_data_i,
	input  wire logic        cmp_valid_i,
	input  wire logic [15:0] alarm_cmp_i,
	input  wire logic [15:0] qtrip_cmp_i,
	input  wire logic [15:0] warn_cmp_i,
	input  wire logic [2:0]  flag_clear_i,
	input  wire logic [7:0]  rdata_o,
	input  wire logic        rd_valid_o,
	input  wire logic [8:0]  modulation_o,
	input  wire logic [2:0]  power_loop_rate_code_o,
	input  wire logic [7:0]  power_loop_period_cyc_o,
	input  wire logic [15:0] alarm_flags_o,
	input  wire logic [15:0] qtrip_flags_o,
	input  wire logic [15:0] warn_flags_o,
	input  wire logic        nv_write_o,
	input  wire logic [7:0]  nv_addr_o
);
	// rights decoded from the password levels, periods in 100 ns cycles
	wire a_top = auth_i.top_password_level;
	wire a_low = auth_i.lower_password_level;
	wire rd_ok = a_top | (a_low & (auth_i.table_rw_grant | auth_i.table_read_grant));
	wire wr_ok = a_top | (a_low & auth_i.table_rw_grant);
	wire cfg_wr = host_i.wr & (host_i.addr >= 8'h88) & (host_i.addr <= 8'h8a);
	localparam logic [7:0] PER [8] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c, 8'h20, 8'h2c, 8'h40};

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	// reload walk: conversion end, then two edges without another
	sequence s_reload;
		(conv_done_i && modulation_lut_enable_i) ##1 (!conv_done_i) [*2];
	endsequence

	a_read_answer: assert property (host_i.rd |=> rd_valid_o)
		else $error("read not answered next cycle");
	a_read_refused: assert property (host_i.rd && !rd_ok |=> rdata_o == 8'h00)
		else $error("read without rights returned data");
	a_rdata_holds: assert property (!host_i.rd |=> $stable(rdata_o))
		else $error("read data moved without a read");
	a_cfg_forward: assert property (cfg_wr && wr_ok |=> nv_write_o && nv_addr_o == $past(host_i.addr))
		else $error("accepted config write not forwarded");
	a_cfg_refused: assert property (cfg_wr && !wr_ok |=> !nv_write_o)
		else $error("refused config write forwarded");
	a_period_map: assert property ($stable(power_loop_rate_code_o) |-> power_loop_period_cyc_o == PER[power_loop_rate_code_o])
		else $error("sample period does not match code");
	a_alarm_sets: assert property (cmp_valid_i |=> (alarm_flags_o & $past(alarm_cmp_i)) == $past(alarm_cmp_i))
		else $error("alarm flag missing after compare");
	a_qtrip_sets: assert property (cmp_valid_i |=> (qtrip_flags_o & $past(qtrip_cmp_i)) == $past(qtrip_cmp_i))
		else $error("quick trip flag missing after compare");
	a_warn_sets: assert property (cmp_valid_i |=> (warn_flags_o & $past(warn_cmp_i)) == $past(warn_cmp_i))
		else $error("warning flag missing after compare");
	a_alarm_holds: assert property (!cmp_valid_i && !flag_clear_i[0] |=> $stable(alarm_flags_o))
		else $error("alarm flags moved without compare");
	a_mod_reload: assert property (s_reload |=> modulation_o == $past(mod_lut_data_i, 3))
		else $error("modulation not reloaded from table");
endmodule // lcr_bank_monitor

bind lcr_bank lcr_bank_monitor mon_u (.*);

//--- verification/lcr_bank_tb.sv
// self-checking bench for the laser control register bank
`timescale 1ns/1ps
module lcr_bank_tb
	import lcr_pkg::*;
;
	logic        core_clk_i, rst_i, conv_done_i, nv_load_i, cmp_valid_i, stop_i;
	logic        modulation_lut_enable_i, aux1_lut_enable_i, aux2_lut_enable_i;
	logic        signal_loss_input_i, signal_loss_low_alarm_i, rate_select_i, gp_input1_i;
	logic [8:0]  mod_lut_data_i, aux1_lut_data_i, aux2_lut_data_i;
	logic [7:0]  nv_rate_i, nv_pincfg_i, nv_outcfg_i, device_addr_i;
	logic [15:0] alarm_cmp_i, qtrip_cmp_i, warn_cmp_i;
	logic [2:0]  flag_clear_i, power_loop_rate_code_o;
	lcr_host_s   host_i;
	lcr_auth_s   auth_i;
	logic [7:0]  rdata_o, power_loop_period_cyc_o, slave_addr_o, alarm_row_table_o, nv_addr_o, nv_wdata_o;
	logic        rd_valid_o, signal_loss_output_o, rate_select_output_o, gp_output1_o, nv_write_o;
	logic [8:0]  modulation_o, aux_output1_o, aux_output2_o;
	logic [15:0] alarm_flags_o, qtrip_flags_o, warn_flags_o;
	int          n_errors, comparisons, cyc;
	logic [7:0]  per_exp [8] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c, 8'h20, 8'h2c, 8'h40};
	logic [8:0]  lut_v [3] = '{9'h1a5, 9'h0f0, 9'h10f};

	lcr_bank dut_u (.*);
	lcr_host_model host_u (.core_clk_i(core_clk_i), .host_o(host_i), .auth_o(auth_i), .stop_o(stop_i));

	initial begin
		core_clk_i = 1'b0;
		forever #50 core_clk_i = ~core_clk_i;
	end

	// hang guard, about four times the few hundred cycles needed
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 1000) begin
			n_errors++;
			test_done();
		end
	end

	task automatic test_done;
		if (n_errors == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// every input change lands 5 ns after an edge
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#5;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic stop);
		host_u.access(1'b1, a, d, stop);
	endtask

	// read data is settled in the cycle after the request
	task automatic expect_rd(input logic [7:0] a, input logic [7:0] e);
		host_u.access(1'b0, a, 8'h00, 1'b0);
		check(rdata_o, e);
	endtask

	// same pattern into all groups, shifted per group to tell them apart
	task automatic cmp_pulse(input logic [15:0] v);
		{alarm_cmp_i, qtrip_cmp_i, warn_cmp_i} = {v, v << 1, v << 2};
		cmp_valid_i = 1'b1;
		tick(1);
		cmp_valid_i = 1'b0;
		tick(1);
	endtask

	function automatic logic [15:0] outs(input int k);
		case (k)
			0: outs = {7'h00, modulation_o};
			1: outs = {7'h00, aux_output1_o};
			2: outs = {7'h00, aux_output2_o};
			3: outs = alarm_flags_o;
			4: outs = qtrip_flags_o;
			default: outs = warn_flags_o;
		endcase
	endfunction

	initial begin
		rst_i = 1'b1;
		{modulation_lut_enable_i, aux1_lut_enable_i, aux2_lut_enable_i, conv_done_i, nv_load_i, cmp_valid_i} = '0;
		{mod_lut_data_i, aux1_lut_data_i, aux2_lut_data_i} = {lut_v[0], lut_v[1], lut_v[2]};
		{nv_rate_i, nv_pincfg_i, nv_outcfg_i, device_addr_i} = 32'hfdffffc4;
		{signal_loss_input_i, signal_loss_low_alarm_i, rate_select_i, gp_input1_i} = 4'ha;
		{alarm_cmp_i, qtrip_cmp_i, warn_cmp_i} = '0;
		flag_clear_i = 3'h0;
		tick(6);
		rst_i = 1'b0;
		// reset contents, then reads under each grant
		host_u.set_auth(4'h8);
		for (int a = 8'h82; a <= 8'h8a; a++) expect_rd(8'(a), a == 8'h89 ? 8'h80 : 8'h00);
		for (int g = 4; g < 7; g++) begin
			host_u.set_auth(4'(g));
			expect_rd(8'h89, g == 4 ? 8'h00 : 8'h80);
		end
		// read-only grant cannot write; every rate code, reserved bits dropped
		host_u.set_auth(4'h5);
		wr(8'h88, 8'h07, 1'b0);
		host_u.set_auth(4'h6);
		expect_rd(8'h88, 8'h00);
		for (int c = 0; c < 8; c++) begin
			wr(8'h88, 8'(c) | 8'hf8, 1'b0);
			tick(2);
			check(power_loop_period_cyc_o, per_exp[c]);
			check(power_loop_rate_code_o, 16'(c));
			check({nv_addr_o, nv_wdata_o}, {8'h88, 8'(c) | 8'hf8});
			expect_rd(8'h88, 8'(c));
		end
		// pin config all ones then all zeros, pins swept
		for (int m = 0; m < 2; m++) begin
			wr(8'h89, m ? 8'h00 : 8'hff, 1'b0);
			expect_rd(8'h89, m ? 8'h00 : 8'hbc);
			for (int p = 0; p < 16; p++) begin
				{signal_loss_input_i, signal_loss_low_alarm_i, rate_select_i, gp_input1_i} = 4'(p);
				tick(2);
				check(signal_loss_output_o, m ? signal_loss_low_alarm_i : !signal_loss_input_i);
				check(rate_select_output_o, m ? rate_select_i : !rate_select_i);
			end
			check(slave_addr_o, m ? 8'ha2 : device_addr_i);
			check(alarm_row_table_o, m ? 8'h01 : 8'h05);
		end
		// force and polarity of the first general output
		for (int m = 0; m < 4; m++) begin
			wr(8'h8a, {m[1:0], 6'h00}, 1'b0);
			for (int p = 0; p < 2; p++) begin
				gp_input1_i = p[0];
				tick(2);
				check(gp_output1_o, (m[1] | p[0]) ^ m[0]);
			end
		end
		// flags follow the last compare, then stay set
		for (int s = 0; s < 2; s++) begin
			wr(8'h8a, s ? 8'h07 : 8'h00, 1'b0);
			cmp_pulse(16'h00f1);
			cmp_pulse(16'h0a10);
			for (int g = 0; g < 3; g++) check(outs(g + 3), (s ? 16'h0af1 : 16'h0a10) << g);
		end
		// a clear empties sticky flags; a compare alongside a clear still sets
		flag_clear_i = 3'h7;
		tick(1);
		check(alarm_flags_o | qtrip_flags_o | warn_flags_o, 16'h0000);
		cmp_valid_i = 1'b1;
		tick(1);
		{flag_clear_i, cmp_valid_i} = 4'h0;
		check(warn_flags_o, 16'h2840);
		// host values, lookup off; output waits for the stop
		for (int v = 0; v < 3; v++) begin
			wr(8'h82 + 8'(2 * v), 8'hff, 1'b0);
			tick(2);
			check(outs(v), 16'h0000);
			wr(8'h83 + 8'(2 * v), 8'h55 + 8'(v), 1'b1);
			tick(2);
			check(outs(v), 16'h0155 + 16'(v));
			expect_rd(8'h82 + 8'(2 * v), 8'h01);
		end
		// refused writes: read-only grant, then lookup owning the values
		host_u.set_auth(4'h5);
		wr(8'h83, 8'h00, 1'b1);
		{modulation_lut_enable_i, aux1_lut_enable_i, aux2_lut_enable_i} = 3'h7;
		host_u.set_auth(4'h8);
		for (int v = 0; v < 3; v++) wr(8'h83 + 8'(2 * v), 8'h00, 1'b1);
		tick(2);
		for (int v = 0; v < 3; v++) check(outs(v), 16'h0155 + 16'(v));
		conv_done_i = 1'b1;
		tick(1);
		conv_done_i = 1'b0;
		tick(3);
		for (int v = 0; v < 3; v++) check(outs(v), {7'h00, lut_v[v]});
		expect_rd(8'h85, lut_v[1][7:0]);
		// shadow recall keeps only the defined bits
		nv_load_i = 1'b1;
		tick(1);
		nv_load_i = 1'b0;
		expect_rd(8'h88, 8'h05);
		expect_rd(8'h89, 8'hbc);
		expect_rd(8'h8a, 8'hc7);
		// second reset clears the volatile value
		rst_i = 1'b1;
		tick(2);
		rst_i = 1'b0;
		check(modulation_o, 9'h000);
		test_done();
	end
endmodule // lcr_bank_tb

//--- verification/lcr_host_model.sv
// serial host model: byte requests, password levels and stop marks
`timescale 1ns/1ps
module lcr_host_model
	import lcr_pkg::*;
(
	input  wire logic core_clk_i,
	output lcr_host_s host_o,
	output lcr_auth_s auth_o,
	output logic      stop_o
);
	// idle bus and no rights at time zero
	initial begin
		host_o = '0;
		auth_o = '0;
		stop_o = 1'b0;
	end

	// password state changes just after an edge
	task automatic set_auth(input logic [3:0] a);
		@(posedge core_clk_i);
		#5;
		auth_o = a;
	endtask

	// one byte request held across one edge; released lines show inverted values
	task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic stop);
		@(posedge core_clk_i);
		#5;
		host_o = {wr, !wr, a, d};
		stop_o = stop;
		@(posedge core_clk_i);
		#5;
		host_o = {2'b00, ~a, ~d};
		stop_o = 1'b0;
	endtask
endmodule // lcr_host_model
